/* File: design/msa_pkg.sv */
// Package for the skip, set, swap and subtract execution datapath
// Summary of operation
// - Byte set writes all ones to memory
// - Bit set drives only selected bit high
// - Increment into acc, memory kept, skip zero
// - Taken skip discards prefetch, inserts dummy cycle
// - Skip takes two cycles taken, else one
// - Bit test skips when selected bit set
// - Acc gets acc plus inverted mem plus one
// - Memory gets acc minus memory byte
// - Acc gets acc minus immediate constant
// - Swap nibbles of memory byte in place
// - Swap nibbles into acc, memory kept
package msa_pkg;
   localparam int DATA_W = 8;
   localparam int BIT_SEL_W = 3;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic [8:0] ONE_CARRY = 9'h001;
   localparam int FLAG_C = 0;
   localparam int FLAG_AC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam logic [3:0] FLAGS_RST = 4'h0;

   typedef enum logic [3:0] {
      MSA_OP_NONE = 4'h0,
      MSA_OP_SUB_BORROW_TO_MEM = 4'h1,
      MSA_OP_DEC_SKIP_ZERO = 4'h2,
      MSA_OP_DEC_TO_ACC_SKIP_ZERO = 4'h3,
      MSA_OP_SET_BYTE = 4'h4,
      MSA_OP_SET_BIT = 4'h5,
      MSA_OP_INC_SKIP_ZERO = 4'h6,
      MSA_OP_INC_TO_ACC_SKIP_ZERO = 4'h7,
      MSA_OP_SKIP_BIT_SET = 4'h8,
      MSA_OP_SUB_TO_ACC = 4'h9,
      MSA_OP_SUB_TO_MEM = 4'ha,
      MSA_OP_SUB_IMM = 4'hb,
      MSA_OP_SWAP = 4'hc,
      MSA_OP_NIBBLE_SWAP_TO_ACC = 4'hd
   } msa_op_t;

   typedef enum logic [0:0] {
      MSA_ST_RUN = 1'b0,
      MSA_ST_DUMMY = 1'b1
   } msa_state_t;

   typedef struct packed {
      msa_op_t op;
      logic [2:0] bit_sel;
      logic [7:0] imm;
   } msa_instr_t;

   typedef struct packed {
      logic [7:0] value;
      logic wr_mem;
      logic wr_acc;
      logic skip;
      logic upd_flags;
      logic [3:0] flags;
   } msa_result_t;

   // Adder with carry in, flags in order ov, z, ac, c
   function automatic logic [11:0] msa_add(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic cin);
      logic [8:0] s;
      logic [4:0] lo;
      logic ov;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      ov = (a[7] == b[7]) && (s[7] != a[7]);
      msa_add = {s[7:0], ov, (s[7:0] == 8'h00), lo[4], s[8]};
   endfunction
endpackage

/* File: design/msa_exec.sv */
// Combinational execute unit for one instruction
`timescale 1ns/1ps
`default_nettype none
module msa_exec
   import msa_pkg::*;
(
   input wire msa_instr_t i_instr,
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_mem,
   input wire logic i_carry,
   output msa_result_t o_res
);
   logic [11:0] sum;
   logic [7:0] dec_v;
   logic [7:0] inc_v;
   logic [7:0] bit_mask;

   always_comb begin
      dec_v = i_mem - ONE_BYTE;
      inc_v = i_mem + ONE_BYTE;
      bit_mask = ONE_BYTE << i_instr.bit_sel;
      sum = msa_add(i_acc, ~i_mem, 1'b1);
      o_res = '0;
      case (i_instr.op)
         MSA_OP_SUB_BORROW_TO_MEM: begin
            sum = msa_add(i_acc, ~i_mem, i_carry);
            o_res.value = sum[11:4];
            o_res.wr_mem = 1'b1;
            o_res.upd_flags = 1'b1;
            o_res.flags = sum[3:0];
         end
         MSA_OP_DEC_SKIP_ZERO: begin
            o_res.value = dec_v;
            o_res.wr_mem = 1'b1;
            o_res.skip = (dec_v == 8'h00);
         end
         MSA_OP_DEC_TO_ACC_SKIP_ZERO: begin
            o_res.value = dec_v;
            o_res.wr_acc = 1'b1;
            o_res.skip = (dec_v == 8'h00);
         end
         MSA_OP_SET_BYTE: begin
            o_res.value = ALL_ONES;
            o_res.wr_mem = 1'b1;
         end
         MSA_OP_SET_BIT: begin
            o_res.value = i_mem | bit_mask;
            o_res.wr_mem = 1'b1;
         end
         MSA_OP_INC_SKIP_ZERO: begin
            o_res.value = inc_v;
            o_res.wr_mem = 1'b1;
            o_res.skip = (inc_v == 8'h00);
         end
         MSA_OP_INC_TO_ACC_SKIP_ZERO: begin
            o_res.value = inc_v;
            o_res.wr_acc = 1'b1;
            o_res.skip = (inc_v == 8'h00);
         end
         MSA_OP_SKIP_BIT_SET: begin
            o_res.skip = |(i_mem & bit_mask);
         end
         MSA_OP_SUB_TO_ACC: begin
            o_res.value = sum[11:4];
            o_res.wr_acc = 1'b1;
            o_res.upd_flags = 1'b1;
            o_res.flags = sum[3:0];
         end
         MSA_OP_SUB_TO_MEM: begin
            o_res.value = sum[11:4];
            o_res.wr_mem = 1'b1;
            o_res.upd_flags = 1'b1;
            o_res.flags = sum[3:0];
         end
         MSA_OP_SUB_IMM: begin
            sum = msa_add(i_acc, ~i_instr.imm, 1'b1);
            o_res.value = sum[11:4];
            o_res.wr_acc = 1'b1;
            o_res.upd_flags = 1'b1;
            o_res.flags = sum[3:0];
         end
         MSA_OP_SWAP: begin
            o_res.value = {i_mem[3:0], i_mem[7:4]};
            o_res.wr_mem = 1'b1;
         end
         MSA_OP_NIBBLE_SWAP_TO_ACC: begin
            o_res.value = {i_mem[3:0], i_mem[7:4]};
            o_res.wr_acc = 1'b1;
         end
         default: begin
            o_res = '0;
         end
      endcase
   end
endmodule // msa_exec
`default_nettype wire

/* File: design/msa_core.sv */
// Top of the datapath: accumulator, flags, memory write and skip control
`timescale 1ns/1ps
`default_nettype none
module msa_core
   import msa_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_valid,
   input wire msa_instr_t i_instr,
   input wire logic [7:0] i_mem_rdata,
   output logic [7:0] o_acc,
   output logic [3:0] o_flags,
   output logic o_mem_we,
   output logic [7:0] o_mem_wdata,
   output logic o_discard,
   output logic o_busy
);
   msa_result_t res;
   msa_state_t state_reg, state_next;
   logic [7:0] acc_reg, acc_next;
   logic [3:0] flags_reg, flags_next;
   logic mem_we_reg, mem_we_next;
   logic [7:0] wdata_reg, wdata_next;
   logic discard_reg, discard_next;
   logic accept;

   msa_exec u_exec (
      .i_instr(i_instr),
      .i_acc(acc_reg),
      .i_mem(i_mem_rdata),
      .i_carry(flags_reg[FLAG_C]),
      .o_res(res)
   );

   // The prefetched word is ignored while the dummy cycle runs
   assign accept = i_valid && (state_reg == MSA_ST_RUN);

   always_comb begin
      state_next = state_reg;
      acc_next = acc_reg;
      flags_next = flags_reg;
      mem_we_next = 1'b0;
      wdata_next = wdata_reg;
      discard_next = 1'b0;
      case (state_reg)
         MSA_ST_RUN: begin
            if (accept) begin
               if (res.wr_acc) begin
                  acc_next = res.value;
               end
               if (res.upd_flags) begin
                  flags_next = res.flags;
               end
               mem_we_next = res.wr_mem;
               if (res.wr_mem) begin
                  wdata_next = res.value;
               end
               if (res.skip) begin
                  state_next = MSA_ST_DUMMY;
                  discard_next = 1'b1;
               end
            end
         end
         MSA_ST_DUMMY: begin
            state_next = MSA_ST_RUN;
         end
         default: begin
            state_next = MSA_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg <= MSA_ST_RUN;
         acc_reg <= ACC_RST;
         flags_reg <= FLAGS_RST;
         mem_we_reg <= 1'b0;
         wdata_reg <= 8'h00;
         discard_reg <= 1'b0;
      end else if (i_ce) begin
         state_reg <= state_next;
         acc_reg <= acc_next;
         flags_reg <= flags_next;
         mem_we_reg <= mem_we_next;
         wdata_reg <= wdata_next;
         discard_reg <= discard_next;
      end
   end

   assign o_acc = acc_reg;
   assign o_flags = flags_reg;
   assign o_mem_we = mem_we_reg;
   assign o_mem_wdata = wdata_reg;
   assign o_discard = discard_reg;
   assign o_busy = (state_reg == MSA_ST_DUMMY);

   // Instruction taken at this edge, as the checks below see it
   logic taken;
   assign taken = i_ce && accept;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_nrst);

   // Results are looked at one edge after the take, where the flops show them
   skip_dummy_a: assert property (
      taken && res.skip |=> o_busy && o_discard)
      else $error("Skip did not insert dummy cycle");

   dummy_len_a: assert property (
      o_busy && i_ce |=> !o_busy)
      else $error("Dummy cycle lasted more than one cycle");

   no_skip_a: assert property (
      taken && !res.skip |=> !o_busy)
      else $error("Unskipped instruction took an extra cycle");

   discard_len_a: assert property (
      o_discard && i_ce |=> !o_discard)
      else $error("Discard pulse lasted more than one cycle");

   // The prefetched word offered in the dummy cycle must leave no trace
   dummy_drop_a: assert property (
      o_busy && i_ce
      |=> !o_mem_we && !o_discard && $stable(o_acc) && $stable(o_flags))
      else $error("Instruction offered in dummy cycle was executed");

   ce_hold_a: assert property (
      !i_ce |=> $stable(o_acc) && $stable(o_flags) && $stable(o_busy)
      && $stable(o_mem_we) && $stable(o_discard))
      else $error("State moved while clock enable was low");

   flag_hold_a: assert property (
      taken && !(i_instr.op inside {MSA_OP_SUB_BORROW_TO_MEM,
      MSA_OP_SUB_TO_ACC, MSA_OP_SUB_TO_MEM, MSA_OP_SUB_IMM})
      |=> $stable(o_flags))
      else $error("Flags moved on an instruction that keeps them");

   borrow_mem_a: assert property (
      taken && i_instr.op == MSA_OP_SUB_BORROW_TO_MEM
      |=> o_mem_we && o_mem_wdata == $past(acc_reg) + ~$past(i_mem_rdata)
      + {7'h00, $past(flags_reg[FLAG_C])} && $stable(o_acc)
      && o_flags[FLAG_Z] == (o_mem_wdata == 8'h00))
      else $error("Subtract with borrow to memory wrong");

   dec_mem_a: assert property (
      taken && i_instr.op == MSA_OP_DEC_SKIP_ZERO
      |=> o_mem_we && o_mem_wdata == $past(i_mem_rdata) - 8'h01
      && o_busy == (o_mem_wdata == 8'h00) && $stable(o_flags))
      else $error("Decrement to memory wrong");

   dec_acc_a: assert property (
      taken && i_instr.op == MSA_OP_DEC_TO_ACC_SKIP_ZERO
      |=> !o_mem_we && o_acc == $past(i_mem_rdata) - 8'h01
      && o_busy == (o_acc == 8'h00))
      else $error("Decrement to accumulator wrong");

   set_byte_a: assert property (
      taken && i_instr.op == MSA_OP_SET_BYTE
      |=> o_mem_we && o_mem_wdata == ALL_ONES)
      else $error("Byte set did not write all ones");

   set_bit_a: assert property (
      taken && i_instr.op == MSA_OP_SET_BIT
      |=> o_mem_we && o_mem_wdata
      == ($past(i_mem_rdata) | (8'h01 << $past(i_instr.bit_sel))))
      else $error("Bit set touched other bits or missed its bit");

   inc_mem_a: assert property (
      taken && i_instr.op == MSA_OP_INC_SKIP_ZERO
      |=> o_mem_we && o_mem_wdata == $past(i_mem_rdata) + 8'h01
      && o_busy == (o_mem_wdata == 8'h00))
      else $error("Increment to memory wrong");

   inc_acc_a: assert property (
      taken && i_instr.op == MSA_OP_INC_TO_ACC_SKIP_ZERO
      |=> !o_mem_we && o_acc == $past(i_mem_rdata) + 8'h01
      && o_busy == (o_acc == 8'h00))
      else $error("Increment to accumulator wrong");

   bit_skip_a: assert property (
      taken && i_instr.op == MSA_OP_SKIP_BIT_SET
      |=> o_busy == $past(i_mem_rdata[i_instr.bit_sel]) && !o_mem_we)
      else $error("Bit test skip wrong");

   sub_acc_a: assert property (
      taken && i_instr.op == MSA_OP_SUB_TO_ACC
      |=> o_acc == $past(acc_reg) - $past(i_mem_rdata) && !o_mem_we
      && o_flags[FLAG_C] == ($past(acc_reg) >= $past(i_mem_rdata)))
      else $error("Subtract to accumulator wrong");

   sub_mem_a: assert property (
      taken && i_instr.op == MSA_OP_SUB_TO_MEM
      |=> o_mem_we && o_mem_wdata == $past(acc_reg) - $past(i_mem_rdata)
      && $stable(o_acc))
      else $error("Subtract to memory wrong");

   sub_imm_a: assert property (
      taken && i_instr.op == MSA_OP_SUB_IMM
      |=> o_acc == $past(acc_reg) - $past(i_instr.imm) && !o_mem_we
      && o_flags[FLAG_C] == ($past(acc_reg) >= $past(i_instr.imm))
      && o_flags[FLAG_Z] == (o_acc == 8'h00))
      else $error("Subtract immediate wrong");

   swap_mem_a: assert property (
      taken && i_instr.op == MSA_OP_SWAP
      |=> o_mem_we
      && o_mem_wdata == {$past(i_mem_rdata[3:0]), $past(i_mem_rdata[7:4])})
      else $error("Swap in memory wrong");

   swap_acc_a: assert property (
      taken && i_instr.op == MSA_OP_NIBBLE_SWAP_TO_ACC
      |=> !o_mem_we
      && o_acc == {$past(i_mem_rdata[3:0]), $past(i_mem_rdata[7:4])})
      else $error("Swap to accumulator wrong");

   skip_taken_c: cover property (taken && res.skip);
   sub_mem_c: cover property (taken && i_instr.op == MSA_OP_SUB_TO_MEM);
   borrow_c: cover property (taken
      && i_instr.op == MSA_OP_SUB_BORROW_TO_MEM && res.flags[FLAG_OV]);
   dummy_offer_c: cover property (o_busy && i_ce && i_valid);
   ce_freeze_c: cover property (!i_ce && i_valid);
endmodule // msa_core
`default_nettype wire

/* File: sim/msa_mem_model.sv */
// Data memory partner: one addressed byte, preset or written back by core
`timescale 1ns/1ps
`default_nettype none
module msa_mem_model (
   input wire logic i_ref_clk,
   input wire logic i_sel,
   input wire logic i_ld,
   input wire logic [7:0] i_ld_val,
   input wire logic i_we,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem_reg;
   always_ff @(posedge i_ref_clk) begin
      if (i_we) begin
         mem_reg <= i_wdata;
      end
   end
   // Unselected reads give the inverse, so a stale byte never looks right
   assign o_rdata = !i_sel ? ~mem_reg : (i_ld ? i_ld_val : mem_reg);
endmodule // msa_mem_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the skip, set, swap and subtract datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
   import msa_pkg::*;
   typedef struct packed {
      msa_op_t op;
      logic [3:0] bs;
      logic [7:0] imm, mem, wd, acc;
      logic [3:0] ws, fl;
   } msa_row_t;
   logic clk, nrst, ce, valid, ld, we, disc, busy;
   msa_instr_t instr;
   logic [7:0] ld_val, rdata, acc, wdata;
   logic [3:0] flags;
   int errors = 0;
   int checked = 0;
   msa_row_t rows[$];

   msa_core msa_core_inst (.i_ref_clk(clk), .i_nrst(nrst), .i_ce(ce),
      .i_valid(valid), .i_instr(instr), .i_mem_rdata(rdata), .o_acc(acc),
      .o_flags(flags), .o_mem_we(we), .o_mem_wdata(wdata),
      .o_discard(disc), .o_busy(busy));
   msa_mem_model msa_mem_model_inst (.i_ref_clk(clk), .i_sel(valid),
      .i_ld(ld), .i_ld_val(ld_val), .i_we(we), .i_wdata(wdata),
      .o_rdata(rdata));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic finish_test;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic void add(input msa_op_t op, input logic [43:0] v);
      rows.push_back(msa_row_t'({op, v}));
   endfunction

   // Row fields: bit, imm, mem, wdata, acc, {we,skip}, flags
   task automatic run(input msa_row_t r);
      instr = '{r.op, r.bs[2:0], r.imm};
      ld_val = r.mem;
      valid = 1'b1;
      @(negedge clk);
      chk({7'h00, we}, {7'h00, r.ws[1]});
      if (r.ws[1]) chk(wdata, r.wd);
      chk(acc, r.acc);
      chk({4'h0, flags}, {4'h0, r.fl});
      chk({6'h00, disc, busy}, {6'h00, r.ws[0], r.ws[0]});
      if (r.ws[0]) begin
         valid = 1'b0;
         @(negedge clk);
         chk({6'h00, disc, busy}, 8'h00);
      end
   endtask

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      valid = 1'b0;
      ld = 1'b1;
      ld_val = 8'h00;
      instr = '{MSA_OP_NONE, 3'h0, 8'h00};
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      add(MSA_OP_INC_TO_ACC_SKIP_ZERO, 44'h0_00_41_00_42_0_0);
      add(MSA_OP_SUB_TO_ACC, 44'h0_00_12_00_30_0_3);
      add(MSA_OP_SUB_IMM, 44'h0_31_00_00_ff_0_0);
      add(MSA_OP_SUB_BORROW_TO_MEM, 44'h0_00_10_ee_ff_2_3);
      add(MSA_OP_SUB_TO_MEM, 44'h0_00_7f_80_ff_2_3);
      add(MSA_OP_SET_BYTE, 44'h0_00_5a_ff_ff_2_3);
      add(MSA_OP_SET_BIT, 44'h5_00_81_a1_ff_2_3);
      add(MSA_OP_SWAP, 44'h0_00_a5_5a_ff_2_3);
      add(MSA_OP_NIBBLE_SWAP_TO_ACC, 44'h0_00_3c_00_c3_0_3);
      add(MSA_OP_SUB_TO_ACC, 44'h0_00_7f_00_44_0_9);
      add(MSA_OP_DEC_SKIP_ZERO, 44'h0_00_02_01_44_2_9);
      add(MSA_OP_DEC_SKIP_ZERO, 44'h0_00_01_00_44_3_9);
      add(MSA_OP_DEC_TO_ACC_SKIP_ZERO, 44'h0_00_01_00_00_1_9);
      add(MSA_OP_DEC_TO_ACC_SKIP_ZERO, 44'h0_00_00_00_ff_0_9);
      add(MSA_OP_INC_SKIP_ZERO, 44'h0_00_ff_00_ff_3_9);
      add(MSA_OP_INC_SKIP_ZERO, 44'h0_00_fe_ff_ff_2_9);
      add(MSA_OP_INC_TO_ACC_SKIP_ZERO, 44'h0_00_ff_00_00_1_9);
      add(MSA_OP_SKIP_BIT_SET, 44'h7_00_80_00_00_1_9);
      add(MSA_OP_SKIP_BIT_SET, 44'h0_00_fe_00_00_0_9);
      add(MSA_OP_SUB_IMM, 44'h0_00_00_00_00_0_7);
      foreach (rows[i]) run(rows[i]);
      // Set offered in the dummy cycle must be dropped
      instr = '{MSA_OP_DEC_SKIP_ZERO, 3'h0, 8'h00};
      ld_val = 8'h01;
      valid = 1'b1;
      @(negedge clk);
      ld = 1'b0;
      instr = '{MSA_OP_SET_BYTE, 3'h0, 8'h00};
      @(negedge clk);
      chk({7'h00, we}, 8'h00);
      instr = '{MSA_OP_INC_TO_ACC_SKIP_ZERO, 3'h0, 8'h00};
      @(negedge clk);
      chk(acc, 8'h01);
      // Clock enable low must freeze everything
      ce = 1'b0;
      instr = '{MSA_OP_SET_BYTE, 3'h0, 8'h00};
      repeat (2) @(negedge clk);
      chk({7'h00, we}, 8'h00);
      chk(acc, 8'h01);
      ce = 1'b1;
      // Reset lands in a dummy cycle: pulses and state clear at once
      ld = 1'b1;
      ld_val = 8'h01;
      instr = '{MSA_OP_DEC_SKIP_ZERO, 3'h0, 8'h00};
      @(negedge clk);
      chk({5'h00, we, disc, busy}, 8'h07);
      chk(wdata, 8'h00);
      nrst = 1'b0;
      valid = 1'b0;
      #1;
      chk({5'h00, we, disc, busy}, 8'h00);
      chk(acc, 8'h00);
      chk({4'h0, flags}, 8'h00);
      @(negedge clk);
      // First instruction may be taken at the first edge after release
      nrst = 1'b1;
      instr = '{MSA_OP_INC_TO_ACC_SKIP_ZERO, 3'h0, 8'h00};
      ld_val = 8'h41;
      valid = 1'b1;
      @(negedge clk);
      chk(acc, 8'h42);
      chk({6'h00, disc, busy}, 8'h00);
      finish_test;
   end

   initial begin
      repeat (1000) @(posedge clk);
      errors++;
      finish_test;
   end
endmodule // tb
`default_nettype wire
